// ===== csirx_top.sv
`timescale 1ns/1ns
// Packet receiver top: byte aligner, header check, payload routing and footer check.
module csirx_top #(
  parameter int LANES = csirx_pkg::LANES_MAX
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic [LANES-1:0] lane_lp,
  input wire logic [LANES-1:0][7:0] lane_byte,
  input wire logic [1:0] lane_count,
  output logic [csirx_pkg::CH_NUM-1:0] cap_valid,
  output logic [15:0] cap_data,
  output logic [1:0] cap_keep,
  output logic cap_start,
  output logic cap_end,
  output logic [5:0] cap_type,
  output logic [csirx_pkg::CH_NUM-1:0] short_valid,
  output logic [15:0] short_data,
  output csirx_pkg::csirx_class_type pkt_class,
  output logic [csirx_pkg::CH_NUM-1:0] frame_active,
  output logic [csirx_pkg::CH_NUM-1:0] line_active,
  output logic err_ecc_fixed,
  output logic err_ecc_fatal,
  output logic err_crc,
  output logic err_trunc,
  output logic err_reserved
);
  import csirx_pkg::*;

  typedef enum logic [1:0] {ST_HEAD, ST_PAY, ST_FOOT, ST_DRAIN} csirx_state_type;

  if (LANES < 1 || LANES > LANES_MAX) begin : g_bad_lanes
    $error("csirx_top: LANES must lie between 1 and 4");
  end

  csirx_word_if words ();

  csirx_lane_merge #(
    .LANES(LANES),
    .DEPTH_LOG2(2)
  ) u_merge (
    .link_clk(link_clk),
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .lane_lp(lane_lp),
    .lane_byte(lane_byte),
    .lane_count(lane_count),
    .words(words.src)
  );

  logic [7:0] buf_r [BUF_BYTES];
  logic [7:0] buf_nxt [BUF_BYTES];
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [3:0] take;
  logic [3:0] left;
  logic flush;
  logic pop_word;
  csirx_state_type state_r;
  logic [15:0] rem_r;
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;
  logic [1:0] ch_r;
  logic first_r;
  logic [25:0] ecc_res;
  logic [7:0] hdr_id;
  logic [15:0] hdr_count;
  logic [1:0] hdr_ch;
  logic [5:0] hdr_dt;

  // Bytes the parser consumes this cycle; a pending end of burst flushes leftovers.
  always_comb begin
    take = 4'd0;
    case (state_r)
      ST_HEAD: begin
        if (cnt_r >= 4'(HDR_BYTES)) begin
          take = 4'(HDR_BYTES);
        end
      end
      ST_PAY: begin
        if (rem_r >= 16'd2 && cnt_r >= 4'd2) begin
          take = 4'd2;
        end else if (rem_r == 16'd1 && cnt_r >= 4'd1) begin
          take = 4'd1;
        end
      end
      ST_FOOT: begin
        if (cnt_r >= 4'(FTR_BYTES)) begin
          take = 4'(FTR_BYTES);
        end
      end
      ST_DRAIN: begin
        take = cnt_r;
      end
      default: begin
        take = 4'd0;
      end
    endcase
    flush = !words.empty && words.last && take == 4'd0 && state_r != ST_DRAIN;
    if (flush) begin
      take = cnt_r;
    end
  end

  assign left = cnt_r - take;
  // An end marker is taken only once every byte ahead of it is consumed.
  assign pop_word = !words.empty &&
                    (words.last ? (left == 4'd0)
                                : (5'(left) + 5'(words.nbytes) <= 5'(BUF_BYTES)));
  assign words.pop = pop_word;
  assign cnt_nxt = left + ((pop_word && !words.last) ? 4'(words.nbytes) : 4'd0);

  always_comb begin
    int src;
    logic [1:0] lane_sel;
    src = 0;
    lane_sel = 2'd0;
    for (int i = 0; i < BUF_BYTES; i++) begin
      src = i + int'(take);
      lane_sel = 2'(src - int'(cnt_r));
      buf_nxt[i] = buf_r[i];
      if (src < int'(cnt_r)) begin
        buf_nxt[i] = buf_r[3'(src)];
      end else if (pop_word && !words.last && src - int'(cnt_r) < int'(words.nbytes)) begin
        buf_nxt[i] = words.data[{lane_sel, 3'b000} +: 8];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'd0;
      for (int i = 0; i < BUF_BYTES; i++) begin
        buf_r[i] <= 8'h00;
      end
    end else begin
      cnt_r <= cnt_nxt;
      for (int i = 0; i < BUF_BYTES; i++) begin
        buf_r[i] <= buf_nxt[i];
      end
    end
  end

  assign ecc_res = ecc_correct({buf_r[2], buf_r[1], buf_r[0]}, buf_r[3]);
  assign hdr_id = ecc_res[7:0];
  assign hdr_count = ecc_res[23:8];
  assign hdr_ch = hdr_id[ID_CH_LSB +: 2];
  assign hdr_dt = hdr_id[ID_DT_LSB +: 6];

  always_comb begin
    crc_nxt = crc_byte(crc_r, buf_r[0]);
    if (take == 4'd2) begin
      crc_nxt = crc_byte(crc_nxt, buf_r[1]);
    end
  end

  // Parser state, payload length and checksum.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_HEAD;
      rem_r <= 16'h0000;
      crc_r <= CRC_SEED;
      ch_r <= 2'd0;
      first_r <= 1'b0;
    end else begin
      case (state_r)
        ST_HEAD: begin
          if (take == 4'(HDR_BYTES) && !flush) begin
            ch_r <= hdr_ch;
            crc_r <= CRC_SEED;
            first_r <= 1'b1;
            rem_r <= hdr_count;
            if (ecc_res[25]) begin
              state_r <= ST_DRAIN;
            end else if (hdr_dt <= DT_SHORT_LAST) begin
              state_r <= ST_HEAD;
            end else if (hdr_dt <= DT_LONG_LAST) begin
              state_r <= (hdr_count == 16'h0000) ? ST_FOOT : ST_PAY;
            end else begin
              state_r <= ST_DRAIN;
            end
          end
        end
        ST_PAY: begin
          if (take != 4'd0 && !flush) begin
            crc_r <= crc_nxt;
            first_r <= 1'b0;
            rem_r <= rem_r - 16'(take);
            if (rem_r == 16'(take)) begin
              state_r <= ST_FOOT;
            end
          end
        end
        ST_FOOT: begin
          if (take == 4'(FTR_BYTES) && !flush) begin
            state_r <= ST_HEAD;
          end
        end
        ST_DRAIN: begin
          state_r <= ST_DRAIN;
        end
        default: begin
          state_r <= ST_HEAD;
        end
      endcase
      if (pop_word && words.last) begin
        state_r <= ST_HEAD;
      end
    end
  end

  // Payload beats to the capture port of the packet's channel.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_valid <= '0;
      cap_data <= 16'h0000;
      cap_keep <= 2'b00;
      cap_start <= 1'b0;
      cap_end <= 1'b0;
      cap_type <= 6'h00;
    end else begin
      cap_valid <= '0;
      if (state_r == ST_HEAD && take == 4'(HDR_BYTES) && !flush) begin
        cap_type <= hdr_dt;
      end
      if (state_r == ST_PAY && take != 4'd0 && !flush) begin
        cap_valid[ch_r] <= 1'b1;
        cap_data <= {(take == 4'd2) ? buf_r[1] : 8'h00, buf_r[0]};
        cap_keep <= (take == 4'd2) ? 2'b11 : 2'b01;
        cap_start <= first_r;
        cap_end <= rem_r == 16'(take);
      end
    end
  end

  // Short packets, class reporting and per-channel frame and line state.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      short_valid <= '0;
      short_data <= 16'h0000;
      pkt_class <= CLS_SYNC_SHORT;
      frame_active <= '0;
      line_active <= '0;
    end else begin
      short_valid <= '0;
      if (state_r == ST_HEAD && take == 4'(HDR_BYTES) && !flush && !ecc_res[25]) begin
        pkt_class <= type_class(hdr_dt);
        if (hdr_dt <= DT_SHORT_LAST) begin
          short_valid[hdr_ch] <= 1'b1;
          short_data <= hdr_count;
          case (hdr_dt)
            DT_FRAME_START: frame_active[hdr_ch] <= 1'b1;
            DT_FRAME_END: frame_active[hdr_ch] <= 1'b0;
            DT_LINE_START: line_active[hdr_ch] <= 1'b1;
            DT_LINE_END: line_active[hdr_ch] <= 1'b0;
            default: line_active[hdr_ch] <= line_active[hdr_ch];
          endcase
        end
      end
    end
  end

  // Error pulses, one cycle each.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_ecc_fixed <= 1'b0;
      err_ecc_fatal <= 1'b0;
      err_crc <= 1'b0;
      err_trunc <= 1'b0;
      err_reserved <= 1'b0;
    end else begin
      err_ecc_fixed <= 1'b0;
      err_ecc_fatal <= 1'b0;
      err_crc <= 1'b0;
      err_trunc <= 1'b0;
      err_reserved <= 1'b0;
      if (state_r == ST_HEAD && take == 4'(HDR_BYTES) && !flush) begin
        err_ecc_fixed <= ecc_res[24];
        err_ecc_fatal <= ecc_res[25];
        err_reserved <= !ecc_res[25] && hdr_dt > DT_LONG_LAST;
      end
      if (state_r == ST_FOOT && take == 4'(FTR_BYTES) && !flush) begin
        err_crc <= {buf_r[1], buf_r[0]} != crc_r;
      end
      if (pop_word && words.last) begin
        // A partial header at a burst end is dropped without an error pulse.
        err_trunc <= state_r == ST_PAY || (state_r == ST_FOOT && take == 4'd0);
      end
    end
  end

endmodule : csirx_top

// ===== csirx_pkg.sv
// Constants, types and checking functions for the camera link packet receiver.
package csirx_pkg;

  localparam int LANES_MAX = 4;
  localparam int CH_NUM = 4;
  localparam int LANE_MBPS_MAX = 1000;
  localparam int LANE_MBPS_FULL = 800;
  localparam logic [7:0] SOT_SYNC = 8'hb8;
  localparam int HDR_BYTES = 4;
  localparam int FTR_BYTES = 2;
  localparam int BUF_BYTES = 8;
  localparam int ID_CH_LSB = 6;
  localparam int ID_DT_LSB = 0;
  localparam logic [5:0] DT_SHORT_LAST = 6'h0f;
  localparam logic [5:0] DT_LONG_LAST = 6'h37;
  localparam logic [5:0] DT_FRAME_START = 6'h00;
  localparam logic [5:0] DT_FRAME_END = 6'h01;
  localparam logic [5:0] DT_LINE_START = 6'h02;
  localparam logic [5:0] DT_LINE_END = 6'h03;
  localparam logic [15:0] CRC_SEED = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [5:0][23:0] ECC_MASK = {24'hef_fc00, 24'hdf_03f0, 24'hb8_e38e,
                                           24'h74_9a6d, 24'hf2_555b, 24'hf1_2cb7};

  typedef enum logic [2:0] {
    CLS_SYNC_SHORT, CLS_GEN_SHORT, CLS_GEN_LONG, CLS_YUV,
    CLS_RGB, CLS_RAW, CLS_USER, CLS_RESERVED
  } csirx_class_type;

  function automatic logic [5:0] ecc_calc(input logic [23:0] d);
    logic [5:0] par;
    par = '0;
    for (int p = 0; p < 6; p++) begin
      par[p] = ^(d & ECC_MASK[p]);
    end
    return par;
  endfunction : ecc_calc

  // Returns {uncorrectable, corrected, repaired data}.
  function automatic logic [25:0] ecc_correct(input logic [23:0] d, input logic [7:0] e);
    logic [5:0] syn;
    logic [5:0] col;
    logic [23:0] fix_d;
    logic hit;
    syn = ecc_calc(d) ^ e[5:0];
    fix_d = d;
    hit = 1'b0;
    col = '0;
    for (int i = 0; i < 24; i++) begin
      for (int p = 0; p < 6; p++) begin
        col[p] = ECC_MASK[p][i];
      end
      if (syn != 6'h00 && col == syn) begin
        fix_d[i] = ~d[i];
        hit = 1'b1;
      end
    end
    if ($countones(syn) == 1) begin
      hit = 1'b1;
    end
    return {syn != 6'h00 && !hit, syn != 6'h00 && hit, fix_d};
  endfunction : ecc_correct

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int j = 0; j < 8; j++) begin
      r = (r[0] ^ b[j]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  function automatic csirx_class_type type_class(input logic [5:0] dt);
    return csirx_class_type'(dt[5:3]);
  endfunction : type_class

endpackage : csirx_pkg

// ===== csirx_word_if.sv
`timescale 1ns/1ns
// Word path from the lane merger crossing to the packet parser.
interface csirx_word_if;
  logic pop;
  logic empty;
  logic last;
  logic [2:0] nbytes;
  logic [31:0] data;
  modport src (input pop, output empty, output last, output nbytes, output data);
  modport snk (output pop, input empty, input last, input nbytes, input data);
endinterface : csirx_word_if

// ===== csirx_lane_merge.sv
`timescale 1ns/1ns
// Lane start and end detection, byte merging and the crossing into the system clock.
module csirx_lane_merge #(
  parameter int LANES = csirx_pkg::LANES_MAX,
  parameter int DEPTH_LOG2 = 2
) (
  input wire logic link_clk,
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [LANES-1:0] lane_lp,
  input wire logic [LANES-1:0][7:0] lane_byte,
  input wire logic [1:0] lane_count,
  csirx_word_if.src words
);
  import csirx_pkg::*;

  localparam int DEPTH = 1 << DEPTH_LOG2;
  localparam int PW = DEPTH_LOG2 + 1;

  if (LANES < 1 || LANES > LANES_MAX || DEPTH_LOG2 < 2) begin : g_bad_param
    $error("csirx_lane_merge: unsupported lane count or depth");
  end

  logic [1:0] lrst_r;
  logic [1:0] cnt_s1_r;
  logic [1:0] cnt_s2_r;
  logic [LANES-1:0] hs_r;
  logic [LANES-1:0] use_mask;
  logic frame_r;
  logic all_hs;
  logic any_lp;
  logic push;
  logic full;
  logic [35:0] mem [DEPTH];
  logic [PW-1:0] wbin_r, wgray_r, rbin_r, rgray_r;
  logic [PW-1:0] rg1_r, rg2_r, wg1_r, wg2_r;
  logic [31:0] word;

  // Reset leaves the link side only on a link clock edge.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrst_r <= 2'b00;
      cnt_s1_r <= 2'b00;
      cnt_s2_r <= 2'b00;
    end else begin
      lrst_r <= {lrst_r[0], 1'b1};
      cnt_s1_r <= lane_count;
      cnt_s2_r <= cnt_s1_r;
    end
  end

  always_comb begin
    word = '0;
    for (int i = 0; i < LANES; i++) begin
      use_mask[i] = (i <= int'(cnt_s2_r));
      word[8*i +: 8] = lane_byte[i];
    end
  end

  assign all_hs = &(hs_r | ~use_mask);
  assign any_lp = |(lane_lp & use_mask);

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_r <= '0;
    end else begin
      for (int i = 0; i < LANES; i++) begin
        if (lane_lp[i]) begin
          hs_r[i] <= 1'b0;
        end else if (lane_byte[i] == SOT_SYNC) begin
          hs_r[i] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_r <= 1'b0;
    end else begin
      frame_r <= all_hs & ~any_lp & lrst_r[1];
    end
  end

  assign push = lrst_r[1] & ((all_hs & ~any_lp) | (frame_r & any_lp)) & ~full;
  assign full = wgray_r == {~rg2_r[PW-1:PW-2], rg2_r[PW-3:0]};

  always_ff @(posedge link_clk) begin
    if (push) begin
      mem[wbin_r[DEPTH_LOG2-1:0]] <= {any_lp, 3'(int'(cnt_s2_r) + 1), word};
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      wbin_r <= '0;
      wgray_r <= '0;
      rg1_r <= '0;
      rg2_r <= '0;
    end else begin
      rg1_r <= rgray_r;
      rg2_r <= rg1_r;
      if (push) begin
        wbin_r <= wbin_r + 1'b1;
        wgray_r <= (wbin_r + 1'b1) ^ ((wbin_r + 1'b1) >> 1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rbin_r <= '0;
      rgray_r <= '0;
      wg1_r <= '0;
      wg2_r <= '0;
    end else begin
      wg1_r <= wgray_r;
      wg2_r <= wg1_r;
      if (words.pop && !words.empty) begin
        rbin_r <= rbin_r + 1'b1;
        rgray_r <= (rbin_r + 1'b1) ^ ((rbin_r + 1'b1) >> 1);
      end
    end
  end

  assign words.empty = rgray_r == wg2_r;
  assign {words.last, words.nbytes, words.data} = mem[rbin_r[DEPTH_LOG2-1:0]];

endmodule : csirx_lane_merge

// ===== csirx_props.sv
`timescale 1ns/1ns
// Checker of output timing, routing and error pulses of the packet receiver.
module csirx_props #(
  parameter int LANES = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic [LANES-1:0] lane_lp,
  input wire logic [LANES-1:0][7:0] lane_byte,
  input wire logic [1:0] lane_count,
  input wire logic [csirx_pkg::CH_NUM-1:0] cap_valid,
  input wire logic [15:0] cap_data,
  input wire logic [1:0] cap_keep,
  input wire logic cap_start,
  input wire logic cap_end,
  input wire logic [5:0] cap_type,
  input wire logic [csirx_pkg::CH_NUM-1:0] short_valid,
  input wire logic [15:0] short_data,
  input wire csirx_pkg::csirx_class_type pkt_class,
  input wire logic [csirx_pkg::CH_NUM-1:0] frame_active,
  input wire logic [csirx_pkg::CH_NUM-1:0] line_active,
  input wire logic err_ecc_fixed,
  input wire logic err_ecc_fatal,
  input wire logic err_crc,
  input wire logic err_trunc,
  input wire logic err_reserved
);
  import csirx_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  cap_onehot_a: assert property ($onehot0(cap_valid))
    else $error("Payload strobe on two channels.");
  short_onehot_a: assert property ($onehot0(short_valid))
    else $error("Short strobe on two channels.");
  beat_marks_a: assert property ((|cap_valid && cap_end) |=> (cap_valid == 0) [*2])
    else $error("Payload beat too soon after an end mark.");
  beat_keep_a: assert property (|cap_valid |-> (cap_end ? cap_keep != 0 : cap_keep == 2'b11))
    else $error("Byte keep wrong on a beat.");
  long_type_a: assert property (|cap_valid |-> cap_type >= 6'h10 && cap_type <= DT_LONG_LAST)
    else $error("Payload beat from a non long type.");
  short_type_a: assert property (|short_valid |-> cap_type <= DT_SHORT_LAST)
    else $error("Short strobe from a long type.");
  frame_rise_a: assert property (|(frame_active & ~$past(frame_active))
    |-> |short_valid && cap_type == DT_FRAME_START) else $error("Frame flag set wrongly.");
  frame_fall_a: assert property (|(~frame_active & $past(frame_active))
    |-> cap_type == DT_FRAME_END) else $error("Frame flag cleared wrongly.");
  line_rise_a: assert property (|(line_active & ~$past(line_active))
    |-> cap_type == DT_LINE_START) else $error("Line flag set wrongly.");
  ecc_excl_a: assert property (!(err_ecc_fixed && err_ecc_fatal))
    else $error("Header both fixed and fatal.");
  fatal_drop_a: assert property (err_ecc_fatal |=> (cap_valid == 0 && short_valid == 0) [*8])
    else $error("Output after a fatal header.");
  reserved_drop_a: assert property (err_reserved |=> (cap_valid == 0) [*8])
    else $error("Payload after a reserved type.");
  crc_pulse_a: assert property (err_crc |=> !err_crc)
    else $error("Checksum error longer than a cycle.");
endmodule : csirx_props
bind csirx_top csirx_props #(.LANES(LANES)) u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .lane_lp(lane_lp),
  .lane_byte(lane_byte), .lane_count(lane_count), .cap_valid(cap_valid),
  .cap_data(cap_data), .cap_keep(cap_keep), .cap_start(cap_start), .cap_end(cap_end),
  .cap_type(cap_type), .short_valid(short_valid), .short_data(short_data),
  .pkt_class(pkt_class), .frame_active(frame_active), .line_active(line_active),
  .err_ecc_fixed(err_ecc_fixed), .err_ecc_fatal(err_ecc_fatal), .err_crc(err_crc),
  .err_trunc(err_trunc), .err_reserved(err_reserved)
);

// ===== csirx_sensor.sv
`timescale 1ns/1ns
// Behavioural camera sensor driving the receiver data lanes.
module csirx_sensor (
  input wire logic link_clk,
  input wire logic [1:0] lane_count,
  output logic [3:0] lane_lp,
  output logic [3:0][7:0] lane_byte
);
  import csirx_pkg::*;
  logic busy;
  initial begin
    busy = 1'b0;
    lane_lp = 4'hf;
    lane_byte = 32'h5a5a_5a5a;
  end
  // Idle lanes show a changing pattern so no stale byte looks valid.
  always @(posedge link_clk) begin
    if (!busy) begin
      lane_byte <= ~lane_byte;
    end
  end
  task automatic send(input logic [7:0] b[$]);
    int n;
    n = int'(lane_count) + 1;
    busy = 1'b1;
    @(posedge link_clk);
    #2;
    for (int l = 0; l < n; l++) begin
      lane_lp[l] = 1'b0;
      lane_byte[l] = SOT_SYNC;
    end
    while (b.size() > 0) begin
      @(posedge link_clk);
      #2;
      for (int l = 0; l < n; l++) begin
        lane_byte[l] = (b.size() > 0) ? b.pop_front() : 8'h00;
      end
    end
    @(posedge link_clk);
    #2;
    lane_lp = 4'hf;
    busy = 1'b0;
  endtask : send
endmodule : csirx_sensor

// ===== csi2_packet_receiver_test.sv
`timescale 1ns/1ns
// Self-checking bench for the camera link packet receiver.
module csi2_packet_receiver_test;
  import csirx_pkg::*;
  logic sys_clk, rst_n, link_clk, cap_start, cap_end;
  logic [1:0] lane_count, cap_keep;
  logic [3:0] lane_lp, cap_valid, short_valid, frame_active, line_active;
  logic [3:0][7:0] lane_byte;
  logic [15:0] cap_data, short_data;
  logic [5:0] cap_type;
  wire [4:0] errs;
  csirx_class_type pkt_class;
  logic [7:0] pk[$];
  logic [23:0] beats[$];
  logic [19:0] shorts[$];
  int ne[5];
  int num_errors = 0;
  int checked = 0;
  csirx_top #(.LANES(4)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk),
    .lane_lp(lane_lp), .lane_byte(lane_byte), .lane_count(lane_count), .cap_valid(cap_valid),
    .cap_data(cap_data), .cap_keep(cap_keep), .cap_start(cap_start), .cap_end(cap_end),
    .cap_type(cap_type), .short_valid(short_valid), .short_data(short_data),
    .pkt_class(pkt_class), .frame_active(frame_active), .line_active(line_active),
    .err_ecc_fixed(errs[0]), .err_ecc_fatal(errs[1]), .err_crc(errs[2]),
    .err_trunc(errs[3]), .err_reserved(errs[4]));
  csirx_sensor sensor (.link_clk(link_clk), .lane_count(lane_count), .lane_lp(lane_lp),
    .lane_byte(lane_byte));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end
  always @(posedge sys_clk) begin
    if (|cap_valid) beats.push_back({cap_valid, cap_start, cap_end, cap_keep, cap_data});
    if (|short_valid) shorts.push_back({short_valid, short_data});
    for (int i = 0; i < 5; i++) ne[i] += int'(errs[i]);
  end
  function automatic logic [5:0] ecc6(input logic [23:0] d);
    logic [5:0] p;
    for (int i = 0; i < 6; i++) p[i] = ^(d & ECC_MASK[i]);
    return p;
  endfunction : ecc6
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
    for (int j = 0; j < 8; j++) c = (c[0] ^ b[j]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    return c;
  endfunction : crc16
  function automatic logic [7:0] pb(input int i, input logic [5:0] dt);
    return 8'(i * 29 + 1) ^ {2'b00, dt};
  endfunction : pb
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic put_hdr(input logic [1:0] ch, input logic [5:0] dt, input logic [15:0] w,
    input logic [23:0] flip);
    logic [23:0] d;
    d = {w, ch, dt};
    for (int i = 0; i < 3; i++) pk.push_back(d[8*i+:8] ^ flip[8*i+:8]);
    pk.push_back({2'b00, ecc6(d)});
  endtask : put_hdr
  task automatic put_long(input logic [1:0] ch, input logic [5:0] dt, input int n,
    input logic [23:0] flip, input logic bad);
    logic [15:0] c;
    c = CRC_SEED;
    put_hdr(ch, dt, 16'(n), flip);
    for (int i = 0; i < n; i++) begin
      pk.push_back(pb(i, dt));
      c = crc16(c, pb(i, dt));
    end
    c = bad ? ~c : c;
    pk.push_back(c[7:0]);
    pk.push_back(c[15:8]);
  endtask : put_long
  task automatic run();
    repeat (10) @(posedge sys_clk);
    #2;
    beats.delete();
    shorts.delete();
    ne = '{default: 0};
    sensor.send(pk);
    pk.delete();
    repeat (30) @(posedge sys_clk);
    #2;
  endtask : run
  task automatic chk_long(input logic [1:0] ch, input logic [5:0] dt, input int n);
    logic [23:0] e;
    logic [23:0] g;
    int m;
    m = (n + 1) / 2;
    chk("beat count", m, beats.size());
    for (int i = 0; i < m && i < beats.size(); i++) begin
      e = {4'b0001 << ch, i == 0, i == m - 1, (2 * i + 1 < n) ? 2'b11 : 2'b01,
        pb(2 * i + 1, dt), pb(2 * i, dt)};
      g = beats[i];
      g[15:8] = (e[17:16] == 2'b01) ? e[15:8] : g[15:8];
      chk("payload beat", e, g);
    end
    chk("type code", dt, cap_type);
    chk("class", dt[5:3], pkt_class);
  endtask : chk_long
  task automatic t_sync();
    put_hdr(2'd1, DT_FRAME_START, 16'h0007, 24'h0);
    put_hdr(2'd1, DT_LINE_START, 16'h0021, 24'h0);
    run();
    chk("frame number", {4'b0010, 16'h0007}, shorts[0]);
    chk("line number", {4'b0010, 16'h0021}, shorts[1]);
    chk("flags set", 8'h22, {frame_active, line_active});
    put_hdr(2'd1, DT_LINE_END, 16'h0021, 24'h0);
    put_hdr(2'd1, DT_FRAME_END, 16'h0007, 24'h0);
    put_hdr(2'd3, 6'h0c, 16'hbeef, 24'h0);
    run();
    chk("generic short", {4'b1000, 16'hbeef}, shorts[2]);
    chk("flags clear", 8'h00, {frame_active, line_active});
    chk("short class", CLS_GEN_SHORT, pkt_class);
    $display("Short packet test done");
  endtask : t_sync
  task automatic t_long();
    logic [5:0] dts[6] = '{6'h10, 6'h18, 6'h20, 6'h28, 6'h30, 6'h37};
    for (int i = 0; i < 6; i++) begin
      put_long(2'(i), dts[i], 2 * i + 2, 24'h0, 1'b0);
      run();
      chk_long(2'(i), dts[i], 2 * i + 2);
      chk("no crc error", 0, ne[2]);
      chk("no truncation", 0, ne[3]);
    end
    for (int k = 0; k < 3; k++) begin
      lane_count = 2'(k);
      put_long(2'(k), 6'h2a, 5 + k, 24'h0, 1'b0);
      run();
      chk_long(2'(k), 6'h2a, 5 + k);
    end
    lane_count = 2'd3;
    $display("Long packet test done");
  endtask : t_long
  task automatic t_faults();
    put_long(2'd3, 6'h24, 4, 24'h0, 1'b1);
    run();
    chk("crc error", 1, ne[2]);
    put_long(2'd0, 6'h24, 4, 24'h00_0100, 1'b0);
    run();
    chk("fixed header", 1, ne[0]);
    chk_long(2'd0, 6'h24, 4);
    put_long(2'd0, 6'h24, 4, 24'h00_0300, 1'b0);
    run();
    chk("fatal header", {32'd1}, {ne[1][15:0], 16'(beats.size())} >> 16);
    chk("fatal drop", 0, beats.size());
    put_hdr(2'd1, 6'h38, 16'h0000, 24'h0);
    put_long(2'd1, 6'h12, 2, 24'h0, 1'b0);
    run();
    chk("reserved", 1, ne[4]);
    chk("reserved drop", 0, beats.size());
    put_long(2'd2, 6'h22, 8, 24'h0, 1'b0);
    repeat (6) void'(pk.pop_back());
    run();
    chk("truncated", 1, ne[3]);
    $display("Fault test done");
  endtask : t_faults
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    rst_n = 1'b0;
    lane_count = 2'd3;
    repeat (4) @(posedge link_clk);
    #2;
    rst_n = 1'b1;
    t_sync();
    t_long();
    t_faults();
    stop_test();
  end
  initial begin
    #200000;
    num_errors++;
    $display("Error watchdog expected end seen timeout");
    stop_test();
  end
endmodule : csi2_packet_receiver_test
